/* File: core/rct2_pkg.sv */
// Package of constants and types for the second reloadable countdown timer
package rct2_pkg;

   // Register indexes; the byte address on the bus is four times the index
   localparam logic [5:0] IDX_CTRL        = 6'h19;
   localparam logic [5:0] IDX_RELOAD_HIGH = 6'h1a;
   localparam logic [5:0] IDX_RELOAD_LOW  = 6'h1b;
   localparam logic [5:0] IDX_COUNT_HIGH  = 6'h1c;
   localparam logic [5:0] IDX_COUNT_LOW   = 6'h1d;
   localparam logic [5:0] IDX_THIRD_CTRL  = 6'h1e;
   localparam logic [5:0] IDX_IRQ_STATUS  = 6'h30;
   localparam logic [5:0] IDX_IRQ_CLEAR   = 6'h31;
   localparam logic [5:0] IDX_IRQ_ENABLE  = 6'h32;
   localparam logic [5:0] IDX_COMMAND     = 6'h33;

   // Bus geometry
   localparam int         ADDR_W = 8;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Control byte: writable bits; bits 6 and 2 always zero
   localparam logic [7:0] CTRL_WMASK = 8'hbb;
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [7:0] RELOAD_RST = 8'h00;
   localparam logic [1:0] IRQ_RST    = 2'h0;

   // Interrupt status bit positions
   localparam int IRQ_BIT_UNDERFLOW = 0;
   localparam int IRQ_BIT_RX_HALT   = 1;

   // Command register bit positions
   localparam int CMD_BIT_START = 0;
   localparam int CMD_BIT_STOP  = 1;

   // Tick rates, derived into phase increments of a 24-bit accumulator
   localparam longint CLK_HZ       = 125000000;
   localparam longint FAST_TICK_HZ = 13560000;
   localparam longint SLOW_TICK_HZ = 212000;
   localparam int     NCO_W        = 24;
   localparam logic [NCO_W-1:0] FAST_INC =
      NCO_W'((FAST_TICK_HZ * (64'h1 << NCO_W)) / CLK_HZ);
   localparam logic [NCO_W-1:0] SLOW_INC =
      NCO_W'((SLOW_TICK_HZ * (64'h1 << NCO_W)) / CLK_HZ);

   // Start mode encodings
   typedef enum logic [1:0] {
      START_MANUAL   = 2'b00,
      START_TX_END   = 2'b01,
      START_LFO_NOUF = 2'b10,
      START_LFO_UF   = 2'b11
   } rct2_start_t;

   // Tick source encodings
   typedef enum logic [1:0] {
      TICK_FAST      = 2'b00,
      TICK_SLOW      = 2'b01,
      TICK_FIRST_UF  = 2'b10,
      TICK_PRECED_UF = 2'b11
   } rct2_tick_t;

   // Control register layout, shared by this and the next timer
   typedef struct packed {
      logic        haltOnReceive;
      logic        resv6;
      rct2_start_t startMode;
      logic        reloadOnZero;
      logic        resv2;
      rct2_tick_t  tickSource;
   } rct2_ctrl_t;

   // Events coming from the frontend around the timer
   typedef struct packed {
      logic txEnd;
      logic rxFirstBits;
      logic firstTimerUnderflow;
      logic precedingTimerUnderflow;
   } rct2_events_t;

endpackage

/* File: core/rct2_timer.sv */
// Second reloadable 16-bit countdown timer with its AXI4-Lite register file
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
// What this block does
// R1: Halt-on-receive stops count after 4 received bits
// R2: Oscillator trimming modes ignore halt-on-receive bit
// R3: Mode 00 manual; mode 01 starts at transmission end
// R4: Modes 10/11 trim oscillator, start/stop on edges
// R5: Auto-restart set reloads and continues at zero, except in mode 10, which stops there
// R6: Auto-restart clear counts to zero and stops
// R7: Every underflow sets the timer interrupt flag
// R8: Source 00 ticks 13.56 MHz, 01 212 kHz
// R9: Source 10 ticks on first timer underflow
// R10: Source 11 ticks on preceding timer underflow
// R11: Start event loads 16-bit reload value
// R12: Reload writes affect only the next start or auto-restart reload
// R13: Reload bytes writable at 1Ah and 1Bh
// R14: Live count readable at 1Ch and 1Dh
// R15: Software avoids reading count during reception
// R16: Next timer control at 1Eh, same layout
// R17: This timer control register sits at 19h
// R18: Decrement one per tick; underflow pulse out
// R19: Reserved control bits read zero, ignore writes
module rct2_timer
   import rct2_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // AXI4-Lite write address and data
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   // AXI4-Lite write response
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   output logic [1:0]             s_axi_bresp,
   // AXI4-Lite read
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   // Frontend events, one-cycle pulses on ref_clk
   input  wire rct2_events_t      events,
   // Low-frequency oscillator pin, asynchronous
   input  wire logic              lowFreqOscPin,
   // Timer outputs
   output logic                   underflowPulse,
   output logic                   timerIrq,
   output rct2_ctrl_t             thirdTimerControl
);

   // Register state
   // The count keeps its last value once stopped
   rct2_ctrl_t ctrl_ff;
   rct2_ctrl_t thirdCtrl_ff;
   logic [7:0]  reloadHigh_ff;
   logic [7:0]  reloadLow_ff;
   logic [15:0] count_ff;
   logic        running_ff;
   logic        underflow_ff;
   logic [1:0]  irqStatus_ff;
   logic [1:0]  irqEnable_ff;

   // Bus state
   // Held halves let address and data come in any order
   logic              awHeld_ff;
   logic [ADDR_W-1:0] awAddr_ff;
   logic              wHeld_ff;
   logic [7:0]        wData_ff;
   logic              wLane0_ff;
   logic              bValid_ff;
   logic [1:0]        bResp_ff;
   logic              rValid_ff;
   logic [31:0]       rData_ff;
   logic [1:0]        rResp_ff;

   // Tick generators and pin synchroniser
   logic [NCO_W-1:0] fastAcc_ff;
   logic [NCO_W-1:0] slowAcc_ff;
   logic             fastTick_ff;
   logic             slowTick_ff;
   logic             lfoSync1_ff;
   logic             lfoSync2_ff;
   logic             lfoSync3_ff;
   logic             lfoLevel_ff;

   // Combinational terms
   // Decoded once so all processes agree on a write
   logic       writeFire;
   logic [5:0] writeIdx;
   logic       writeHit;
   logic       lfoRise;
   logic       lfoMode;
   logic       tick;
   logic       swStart;
   logic       swStop;
   logic       rxHalt;
   logic       startEvt;
   logic       stopEvt;
   logic       zeroHit;
   logic       underflowEvt;

   // Word index of an aligned byte address
   function automatic logic [5:0] wordIdx(input logic [ADDR_W-1:0] addr);
      return addr[ADDR_W-1:2];
   endfunction

   // Whether an address maps to a register
   function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
      logic [5:0] idx;
      idx = wordIdx(addr);
      return (addr[1:0] == 2'h0) &&
             ((idx >= IDX_CTRL && idx <= IDX_THIRD_CTRL) ||
              (idx >= IDX_IRQ_STATUS && idx <= IDX_COMMAND));
   endfunction

   // Read value of a register; write-only ones read zero
   function automatic logic [7:0] readValue(input logic [5:0] idx);
      case (idx)
         IDX_CTRL:        return ctrl_ff;
         IDX_RELOAD_HIGH: return reloadHigh_ff;
         IDX_RELOAD_LOW:  return reloadLow_ff;
         IDX_COUNT_HIGH:  return count_ff[15:8];
         IDX_COUNT_LOW:   return count_ff[7:0];
         IDX_THIRD_CTRL:  return thirdCtrl_ff;
         IDX_IRQ_STATUS:  return {6'h00, irqStatus_ff};
         IDX_IRQ_ENABLE:  return {6'h00, irqEnable_ff};
         IDX_COMMAND:     return {7'h00, running_ff};
         default:         return 8'h00;
      endcase
   endfunction

   // One write and one read in flight at most
   // A second address waits for the commit
   // Handshake outputs straight from holding state
   assign s_axi_awready = !awHeld_ff;
   assign s_axi_wready  = !wHeld_ff;
   assign s_axi_bvalid  = bValid_ff;
   assign s_axi_bresp   = bResp_ff;
   assign s_axi_arready = !rValid_ff;
   assign s_axi_rvalid  = rValid_ff;
   assign s_axi_rdata   = rData_ff;
   assign s_axi_rresp   = rResp_ff;

   // A write commits once both halves are held and the last response is gone
   assign writeFire = awHeld_ff && wHeld_ff && !bValid_ff;
   assign writeIdx  = wordIdx(awAddr_ff);
   assign writeHit  = writeFire && wLane0_ff && isMapped(awAddr_ff);

   // Write address capture
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         awHeld_ff <= 1'b0;
         awAddr_ff <= '0;
      end else if (s_axi_awvalid && !awHeld_ff) begin
         awHeld_ff <= 1'b1;
         awAddr_ff <= s_axi_awaddr;
      end else if (writeFire) begin
         awHeld_ff <= 1'b0;
      end
   end

   // Write data capture; only byte lane 0 carries register data
   // Upper lanes are ignored: registers are one byte
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wHeld_ff  <= 1'b0;
         wData_ff  <= 8'h00;
         wLane0_ff <= 1'b0;
      end else if (s_axi_wvalid && !wHeld_ff) begin
         wHeld_ff  <= 1'b1;
         wData_ff  <= s_axi_wdata[7:0];
         wLane0_ff <= s_axi_wstrb[0];
      end else if (writeFire) begin
         wHeld_ff <= 1'b0;
      end
   end

   // Write response; unmapped addresses answer SLVERR
   // Holding bready low stalls the next write too
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bValid_ff <= 1'b0;
         bResp_ff  <= RESP_OKAY;
      end else if (writeFire) begin
         bValid_ff <= 1'b1;
         bResp_ff  <= isMapped(awAddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bValid_ff <= 1'b0;
      end
   end

   // Read channel; data sampled at the address handshake
   // Count bytes are two reads and may move between them;
   // Read them with the timer stopped
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rValid_ff <= 1'b0;
         rData_ff  <= 32'h0000_0000;
         rResp_ff  <= RESP_OKAY;
      end else if (s_axi_arvalid && !rValid_ff) begin
         rValid_ff <= 1'b1;
         rData_ff  <= {24'h00_0000, readValue(wordIdx(s_axi_araddr))}; // [R14]
         rResp_ff  <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rValid_ff <= 1'b0;
      end
   end

   // Control registers; reserved bits masked off on write
   // The next timer's byte is only stored and passed out
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_ff      <= CTRL_RST;
         thirdCtrl_ff <= CTRL_RST;
      end else if (writeHit && writeIdx == IDX_CTRL) begin
         ctrl_ff <= wData_ff & CTRL_WMASK; // [R17] [R19]
      end else if (writeHit && writeIdx == IDX_THIRD_CTRL) begin
         thirdCtrl_ff <= wData_ff & CTRL_WMASK; // [R16] [R19]
      end
   end

   // Reload bytes; stored only, the counter picks them up at a start
   // A write mid-count leaves the countdown alone
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reloadHigh_ff <= RELOAD_RST;
         reloadLow_ff  <= RELOAD_RST;
      end else if (writeHit && writeIdx == IDX_RELOAD_HIGH) begin
         reloadHigh_ff <= wData_ff; // [R13] [R12]
      end else if (writeHit && writeIdx == IDX_RELOAD_LOW) begin
         reloadLow_ff <= wData_ff; // [R13] [R12]
      end
   end

   // Interrupt enable
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irqEnable_ff <= IRQ_RST;
      end else if (writeHit && writeIdx == IDX_IRQ_ENABLE) begin
         irqEnable_ff <= wData_ff[1:0];
      end
   end

   // Phase accumulators: the carry is the tick, jitter is one ref_clk period
   // Average rate is exact to a fraction of a ppm for the fast tick; the slow tick runs about 6 ppm low
   // No divided clock: all logic stays on ref_clk
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fastAcc_ff  <= '0;
         slowAcc_ff  <= '0;
         fastTick_ff <= 1'b0;
         slowTick_ff <= 1'b0;
      end else begin
         {fastTick_ff, fastAcc_ff} <= {1'b0, fastAcc_ff} + {1'b0, FAST_INC}; // [R8]
         {slowTick_ff, slowAcc_ff} <= {1'b0, slowAcc_ff} + {1'b0, SLOW_INC}; // [R8]
      end
   end

   // Oscillator pin: three stages, level moves only when stages 2 and 3 agree
   // The pin is free-running, so nothing else reads stage 1
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lfoSync1_ff <= 1'b0;
         lfoSync2_ff <= 1'b0;
         lfoSync3_ff <= 1'b0;
         lfoLevel_ff <= 1'b0;
      end else begin
         lfoSync1_ff <= lowFreqOscPin;
         lfoSync2_ff <= lfoSync1_ff;
         lfoSync3_ff <= lfoSync2_ff;
         if (lfoSync2_ff == lfoSync3_ff) begin
            lfoLevel_ff <= lfoSync3_ff;
         end
      end
   end

   // Rising edge of the filtered level; reset level equals idle pin
   assign lfoRise = (lfoSync2_ff == lfoSync3_ff) && lfoSync3_ff && !lfoLevel_ff;

   // Tick selection
   // Sibling underflows already are one-cycle pulses
   always_comb begin
      case (ctrl_ff.tickSource)
         TICK_FAST:      tick = fastTick_ff; // [R8]
         TICK_SLOW:      tick = slowTick_ff; // [R8]
         TICK_FIRST_UF:  tick = events.firstTimerUnderflow; // [R9]
         TICK_PRECED_UF: tick = events.precedingTimerUnderflow; // [R10]
         default:        tick = 1'b0;
      endcase
   end

   // Start and stop causes; a stop wins over a start in the same cycle
   // A start while running reloads at once
   // Software may restart without a stop first
   assign lfoMode  = ctrl_ff.startMode[1]; // [R4]
   assign swStart  = writeHit && writeIdx == IDX_COMMAND && wData_ff[CMD_BIT_START]; // [R3]
   assign swStop   = writeHit && writeIdx == IDX_COMMAND && wData_ff[CMD_BIT_STOP];
   assign rxHalt   = running_ff && !lfoMode && ctrl_ff.haltOnReceive
                     && events.rxFirstBits; // [R1] [R2]
   assign startEvt = swStart
                     || (ctrl_ff.startMode == START_TX_END && events.txEnd) // [R3]
                     || (lfoMode && lfoRise && !running_ff); // [R4]
   assign stopEvt  = swStop || rxHalt || (lfoMode && lfoRise && running_ff); // [R4]

   // Zero reached on a tick; trimming without underflow just stops there
   // Underflow is a tick at zero: reload N spans N+1 ticks
   // In mode 10 the count left at the stop is the result
   assign zeroHit      = running_ff && tick && count_ff == 16'h0000;
   assign underflowEvt = zeroHit && ctrl_ff.startMode != START_LFO_NOUF; // [R4]

   // Counter and run state
   // A halt is never lost to a start in the same cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         count_ff   <= 16'h0000;
         running_ff <= 1'b0;
      end else if (stopEvt) begin
         running_ff <= 1'b0; // [R1]
      end else if (startEvt) begin
         count_ff   <= {reloadHigh_ff, reloadLow_ff}; // [R11]
         running_ff <= 1'b1;
      end else if (zeroHit) begin
         if (ctrl_ff.reloadOnZero && underflowEvt) begin
            count_ff <= {reloadHigh_ff, reloadLow_ff}; // [R5]
         end else begin
            running_ff <= 1'b0; // [R6]
         end
      end else if (running_ff && tick) begin
         count_ff <= count_ff - 16'h0001; // [R18]
      end
   end

   // Underflow pulse for sibling timers
   // Registered: siblings see it a cycle after the tick
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         underflow_ff <= 1'b0;
      end else begin
         underflow_ff <= underflowEvt; // [R18]
      end
   end

   // Sticky status; a set in the clearing cycle survives the clear
   // Bit 0 marks underflow, bit 1 a halt by the receiver
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irqStatus_ff <= IRQ_RST;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == IRQ_BIT_UNDERFLOW && underflowEvt) // [R7]
                || (i == IRQ_BIT_RX_HALT && rxHalt)) begin
               irqStatus_ff[i] <= 1'b1;
            end else if (writeHit && writeIdx == IDX_IRQ_CLEAR && wData_ff[i]) begin
               irqStatus_ff[i] <= 1'b0;
            end
         end
      end
   end

   // Outputs
   // The interrupt is a level until cleared or masked
   assign underflowPulse    = underflow_ff;
   assign timerIrq          = |(irqStatus_ff & irqEnable_ff);
   assign thirdTimerControl = thirdCtrl_ff;

endmodule

/* File: verification/rct2_timer_monitor.sv */
// Port checks for the second reloadable countdown timer
`timescale 1ns/1ps
module rct2_timer_monitor
   import rct2_pkg::*;
(
   // Clock and reset
   input wire logic              ref_clk,
   input wire logic              rst,
   // Register bus
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic [31:0]       s_axi_wdata,
   input wire logic [3:0]        s_axi_wstrb,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic              s_axi_rvalid,
   input wire logic [31:0]       s_axi_rdata,
   // Timer outputs
   input wire logic              underflowPulse,
   input wire logic              timerIrq,
   input wire rct2_ctrl_t        thirdTimerControl
);
   logic [7:0] rdAddr_ff;
   logic [7:0] thirdData_ff;
   logic       ufEn_ff;
   logic       wrTake;
   // Only writes with address and data taken together are shadowed
   assign wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                   && s_axi_wstrb[0];
   // Shadow of read address, third control byte and underflow enable
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdAddr_ff <= 8'h00;
         thirdData_ff <= 8'h00;
         ufEn_ff <= 1'b0;
      end else begin
         if (s_axi_arvalid && s_axi_arready) rdAddr_ff <= s_axi_araddr;
         if (wrTake && s_axi_awaddr == {IDX_THIRD_CTRL, 2'b00}) thirdData_ff <= s_axi_wdata[7:0];
         if (wrTake && s_axi_awaddr == {IDX_IRQ_ENABLE, 2'b00}) ufEn_ff <= s_axi_wdata[0];
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   pulse_single_a: assert property (underflowPulse |=> !underflowPulse)
      else $error("underflow pulse longer than one cycle");
   irq_on_uf_a: assert property (underflowPulse && ufEn_ff |-> ##[0:2] timerIrq)
      else $error("underflow did not raise the interrupt");
   third_copy_a: assert property (wrTake && s_axi_awaddr == {IDX_THIRD_CTRL, 2'b00}
      |-> ##[2:3] thirdTimerControl == (thirdData_ff & CTRL_WMASK))
      else $error("third control output differs from written byte");
   third_resv_a: assert property (!thirdTimerControl.resv6 && !thirdTimerControl.resv2)
      else $error("third control reserved bit set");
   ctrl_resv_a: assert property (s_axi_rvalid && rdAddr_ff == {IDX_CTRL, 2'b00}
      |-> !s_axi_rdata[6] && !s_axi_rdata[2])
      else $error("control reserved bit read as one");
   wr_answer_a: assert property (wrTake && !s_axi_bvalid |-> ##2 s_axi_bvalid)
      else $error("write response late");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000)
      else $error("read answer late or upper bits set");
   rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted while data pending");
endmodule
bind rct2_timer rct2_timer_monitor mon (.ref_clk(ref_clk), .rst(rst),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rdata(s_axi_rdata), .underflowPulse(underflowPulse), .timerIrq(timerIrq),
   .thirdTimerControl(thirdTimerControl));

/* File: verification/rct2_tb.sv */
// Directed bench for the second reloadable countdown timer
`timescale 1ns/1ps
module tb
   import rct2_pkg::*;
;
   logic              ref_clk = 1'b0;
   logic              rst = 1'b1;
   logic              s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awready, s_axi_wready;
   logic              s_axi_bvalid, s_axi_arready, s_axi_rvalid, lowFreqOscPin;
   logic              underflowPulse, timerIrq, uf;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0]       s_axi_wdata, s_axi_rdata;
   logic [1:0]        s_axi_bresp, s_axi_rresp;
   rct2_events_t      events;
   rct2_ctrl_t        thirdTimerControl;
   int                n_mismatch = 0;
   int                checked = 0;
   // Bit positions of the frontend events
   localparam int EV_TX = 3, EV_RX = 2, EV_FIRST = 1, EV_PREC = 0;
   rct2_timer uut (.ref_clk(ref_clk), .rst(rst),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'h1), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
      .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .events(events),
      .lowFreqOscPin(lowFreqOscPin), .underflowPulse(underflowPulse), .timerIrq(timerIrq),
      .thirdTimerControl(thirdTimerControl));
   always #4 ref_clk = ~ref_clk;
   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // A bus answer that never came ends the run
   task automatic bound(input int n);
      if (n == 50) begin
         n_mismatch++;
         test_done();
      end
   endtask
   // Ready lines are both tied high, so bvalid and rvalid are taken when seen
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      int n;
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      bound(n);
      chk("bresp", {30'h0, RESP_OKAY}, {30'h0, s_axi_bresp});
   endtask
   task automatic rd(input logic [5:0] idx, input logic [1:0] er, output logic [31:0] d);
      int n;
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge ref_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      bound(n);
      d = s_axi_rdata;
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask
   task automatic rde(input logic [5:0] idx, input logic [31:0] e, input string what);
      logic [31:0] d;
      rd(idx, RESP_OKAY, d);
      chk(what, e, d);
   endtask
   // Counts are read only with no frame being received
   task automatic cnt(input logic [15:0] e);
      rde(IDX_COUNT_HIGH, {24'h0, e[15:8]}, "count high");
      rde(IDX_COUNT_LOW, {24'h0, e[7:0]}, "count low");
   endtask
   task automatic run(input logic r);
      rde(IDX_COMMAND, {31'h0, r}, "running");
   endtask
   task automatic rl(input logic [15:0] v);
      wr(IDX_RELOAD_HIGH, v[15:8]);
      wr(IDX_RELOAD_LOW, v[7:0]);
   endtask
   // One event pulse, then long enough to catch the registered underflow
   task automatic pulse(input int b);
      events <= rct2_events_t'(4'b0001 << b);
      @(posedge ref_clk);
      events <= '0;
      uf = 1'b0;
      repeat (4) begin
         @(posedge ref_clk);
         uf = uf | underflowPulse;
      end
   endtask
   // Synchroniser needs a few cycles to see the pin rise
   task automatic pinEdge();
      lowFreqOscPin <= 1'b1;
      repeat (8) @(posedge ref_clk);
      lowFreqOscPin <= 1'b0;
      repeat (8) @(posedge ref_clk);
   endtask
   task automatic test_regs();
      logic [31:0] d;
      rde(IDX_CTRL, 32'h0, "ctrl reset");
      wr(IDX_CTRL, 8'hff);
      rde(IDX_CTRL, 32'hbb, "ctrl mask");
      wr(IDX_THIRD_CTRL, 8'hff);
      rde(IDX_THIRD_CTRL, 32'hbb, "third ctrl");
      chk("third port", 32'hbb, {24'h0, thirdTimerControl});
      rl(16'ha55a);
      rde(IDX_RELOAD_HIGH, 32'ha5, "reload high");
      rde(IDX_RELOAD_LOW, 32'h5a, "reload low");
      wr(IDX_COUNT_HIGH, 8'h77);
      cnt(16'h0000);
      rd(6'h20, RESP_SLVERR, d);
      chk("unmapped", 32'h0, d);
      wr(IDX_THIRD_CTRL, 8'h00);
      $display("test regs done");
   endtask
   task automatic test_timer();
      wr(IDX_IRQ_ENABLE, 8'h01);
      rl(16'h0002);
      wr(IDX_CTRL, 8'h02);
      pulse(EV_TX);
      run(1'b0);
      wr(IDX_COMMAND, 8'h01);
      cnt(16'h0002);
      rl(16'h0009);
      pulse(EV_FIRST);
      cnt(16'h0001);
      pulse(EV_PREC);
      cnt(16'h0001);
      pulse(EV_FIRST);
      pulse(EV_FIRST);
      chk("underflow", 32'h1, {31'h0, uf});
      chk("irq", 32'h1, {31'h0, timerIrq});
      cnt(16'h0000);
      run(1'b0);
      wr(IDX_IRQ_CLEAR, 8'h01);
      chk("irq clear", 32'h0, {31'h0, timerIrq});
      wr(IDX_COMMAND, 8'h01);
      cnt(16'h0009);
      wr(IDX_CTRL, 8'h0b);
      rl(16'h0001);
      wr(IDX_COMMAND, 8'h01);
      pulse(EV_PREC);
      pulse(EV_PREC);
      chk("restart uf", 32'h1, {31'h0, uf});
      cnt(16'h0001);
      run(1'b1);
      wr(IDX_COMMAND, 8'h02);
      wr(IDX_IRQ_CLEAR, 8'h01);
      $display("test timer done");
   endtask
   task automatic test_modes();
      rl(16'h0004);
      wr(IDX_CTRL, 8'h93);
      pulse(EV_TX);
      cnt(16'h0004);
      pulse(EV_RX);
      pulse(EV_PREC);
      cnt(16'h0004);
      rde(IDX_IRQ_STATUS, 32'h2, "halt flag");
      wr(IDX_CTRL, 8'h13);
      pulse(EV_TX);
      pulse(EV_RX);
      pulse(EV_PREC);
      cnt(16'h0003);
      rl(16'h0001);
      wr(IDX_COMMAND, 8'h02);
      wr(IDX_CTRL, 8'ha3);
      pinEdge();
      pulse(EV_RX);
      run(1'b1);
      pulse(EV_PREC);
      pulse(EV_PREC);
      chk("trim no uf", 32'h0, {31'h0, uf});
      run(1'b0);
      wr(IDX_CTRL, 8'h33);
      pinEdge();
      pinEdge();
      run(1'b0);
      pinEdge();
      pulse(EV_PREC);
      pulse(EV_PREC);
      chk("trim uf", 32'h1, {31'h0, uf});
      wr(IDX_IRQ_CLEAR, 8'h01);
      $display("test modes done");
   endtask
   task automatic test_rate();
      logic [31:0] hi, lo;
      int          ticks, exp;
      rl(16'hffff);
      for (int s = 0; s < 2; s++) begin
         wr(IDX_CTRL, 8'(s));
         wr(IDX_COMMAND, 8'h01);
         repeat (s ? 5000 : 1250) @(posedge ref_clk);
         wr(IDX_COMMAND, 8'h02);
         rd(IDX_COUNT_HIGH, RESP_OKAY, hi);
         rd(IDX_COUNT_LOW, RESP_OKAY, lo);
         ticks = 65535 - int'({hi[7:0], lo[7:0]});
         exp = (s ? 5002 * 212 : 1252 * 13560) / 125000;
         checked++;
         if (ticks < exp - 3 || ticks > exp + 3) begin
            n_mismatch++;
            $display("[ERR] tick count expected %0d seen %0d", exp, ticks);
         end
      end
      $display("test rate done");
   endtask
   initial begin
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      s_axi_arvalid <= 1'b0;
      s_axi_awaddr <= '0;
      s_axi_araddr <= '0;
      s_axi_wdata <= '0;
      events <= '0;
      lowFreqOscPin <= 1'b0;
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      test_regs();
      test_timer();
      test_modes();
      test_rate();
      test_done();
   end
endmodule
